// [logic/hvii_pkg.sv]
/*
  Constants, register map and types for the high voltage indirect
  register interface. Assumes a 20 MHz system clock and an AHB-Lite bus.
*/
// What this block does
// - Command byte starts indirect read or write
// - Two-line serial link, clock near 2.56 MHz
// - Command reaches far die within 10 us
// - Read data lands in data register within 10 us
// - Codes 00-03 read the four indirect registers
// - Codes 08/09 write first/second configuration register
// - Busy bit 0 set while command runs
// - Busy clear means status bits valid
// - Bit 2 reports send success
// - Bit 1 reports read-back success; 7..3 reserved
// - Data bits 11..8 show associated command code
// - Data bits 7..0 hold byte sent or returned
// - Configuration registers eight bits, reset zero
`default_nettype none
package hvii_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CMD      = 32'hFFFF0804;
  localparam logic [31:0] ADDR_DATA     = 32'hFFFF080C;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFFF0810;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFF0814;
  // Command codes
  localparam logic [7:0] CMD_RD_CFG1 = 8'h00;
  localparam logic [7:0] CMD_RD_CFG2 = 8'h01;
  localparam logic [7:0] CMD_RD_STA  = 8'h02;
  localparam logic [7:0] CMD_RD_MON  = 8'h03;
  localparam logic [7:0] CMD_WR_CFG1 = 8'h08;
  localparam logic [7:0] CMD_WR_CFG2 = 8'h09;
  // Field positions
  localparam int BUSY_BIT  = 0;
  localparam int RX_OK_BIT = 1;
  localparam int TX_OK_BIT = 2;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAIL  = 1;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [11:0] DATA_RESET = 12'h000;
  // Timing
  localparam int CLK_KHZ    = 20000;
  localparam int LINK_KHZ   = 2560;
  localparam int HALF_CYC   = (CLK_KHZ + 2 * LINK_KHZ - 1) / (2 * LINK_KHZ);
  localparam int LATENCY_US = 10;
  localparam int LATENCY_CYC = LATENCY_US * CLK_KHZ / 1000;
  // Frame: start, 4 code bits, 8 data bits, acknowledge
  localparam logic [3:0] FRAME_LAST = 4'd13;
  localparam logic [3:0] OUT_LAST_RD = 4'd4;
  localparam logic [3:0] OUT_LAST_WR = 4'd12;
  localparam logic [2:0] PHASE_LAST  = 3'(2 * HALF_CYC - 1);
  localparam logic [2:0] PHASE_HIGH  = 3'(HALF_CYC);

  typedef enum logic {ST_IDLE, ST_XFER} hvii_state_t;
endpackage
`default_nettype wire

// [logic/hvii_sync.sv]
/*
  Two flip-flop synchroniser for signals from outside the mclk domain.
  Assumes the input is a slow level; nothing reads the first stage.
*/
`timescale 1ns/100ps
`default_nettype none
module hvii_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,  // System clock
  input  wire logic             rst,   // Synchronous reset
  input  wire logic [WIDTH-1:0] async, // Level from outside
  output logic      [WIDTH-1:0] sync   // Level in mclk domain
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async;
      sync_reg <= meta_reg;
    end
  end

  assign sync = sync_reg;
endmodule
`default_nettype wire

// [logic/hvii_top.sv]
/*
  Command interpreter reaching four indirect registers on a far die over
  a two-line serial link. Assumes an AHB-Lite master on mclk and a far
  end that follows the frame format used here.
*/
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module hvii_top
  import hvii_pkg::*;
(
  input  wire logic        mclk,      // 20 MHz system clock
  input  wire logic        rst,       // Synchronous reset, high
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Word only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic             hresp,     // Always OKAY
  output logic      [31:0] hrdata,    // Read data
  output logic             sclkOut,   // Serial clock to far die
  input  wire logic        sdaIn,     // Serial data line level
  output logic             sdaOut,    // Serial data driven value
  output logic             sdaOe,     // High while driving data
  output logic             irq,       // Level interrupt
  output logic      [7:0]  cfgFirst,  // Mirror of first config
  output logic      [7:0]  cfgSecond  // Mirror of second config
);
  hvii_state_t state_reg, state_next;
  logic        dpWrite_reg, rdWait_reg;
  logic [31:0] dpAddr_reg, hrdata_reg;
  logic [2:0]  phase_reg;
  logic [3:0]  bitIdx_reg;
  logic [12:0] txShift_reg;
  logic [7:0]  rxShift_reg, txByte_reg;
  logic [3:0]  code_reg;
  logic        isRead_reg, txOk_reg, rxOk_reg, sclk_reg;
  logic [11:0] data_reg;
  logic [1:0]  irqStat_reg, irqMask_reg;
  logic [7:0]  cfgFirst_reg, cfgSecond_reg;
  logic        sdaSync;

  // Line level comes from the far die, so synchronise first
  hvii_sync #(.WIDTH(1)) uSync
  (
    .mclk  (mclk),
    .rst   (rst),
    .async (sdaIn),
    .sync  (sdaSync)
  );

  // Bus decode
  wire        wordXfer  = (hsize == 3'h2); // Narrow transfers are ignored
  wire        addrPhase = hsel & htrans[1] & hready & wordXfer;
  wire        wrCmd     = dpWrite_reg & (dpAddr_reg == ADDR_CMD);
  wire        wrData    = dpWrite_reg & (dpAddr_reg == ADDR_DATA);
  wire        wrStat    = dpWrite_reg & (dpAddr_reg == ADDR_IRQ_STAT);
  wire        wrMask    = dpWrite_reg & (dpAddr_reg == ADDR_IRQ_MASK);
  wire [7:0]  cmdByte   = hwdata[7:0];
  wire        busy      = (state_reg == ST_XFER);

  // Command interpretation; busy writes are dropped, not queued
  wire codeIsRead  = (cmdByte == CMD_RD_CFG1) | (cmdByte == CMD_RD_CFG2)
                   | (cmdByte == CMD_RD_STA) | (cmdByte == CMD_RD_MON);
  wire codeIsWrite = (cmdByte == CMD_WR_CFG1) | (cmdByte == CMD_WR_CFG2);
  wire cmdAccept   = wrCmd & ~busy;
  wire start       = cmdAccept & (codeIsRead | codeIsWrite);
  wire badCode     = cmdAccept & ~(codeIsRead | codeIsWrite);

  // Serial timing
  wire bitEnd   = busy & (phase_reg == PHASE_LAST);
  wire frameEnd = bitEnd & (bitIdx_reg == FRAME_LAST);
  wire inByte   = (bitIdx_reg > OUT_LAST_RD) & (bitIdx_reg <= OUT_LAST_WR);
  wire ackOk    = sdaSync;
  wire sclkNext = busy & ~frameEnd & (bitEnd ? 1'b0 : (phase_reg + 3'd1 >= PHASE_HIGH));

  // Register read mux
  wire [31:0] cmdView  = {29'h0, txOk_reg, rxOk_reg, busy};
  wire [31:0] readMux  =
    (dpAddr_reg == ADDR_CMD)      ? cmdView :
    (dpAddr_reg == ADDR_DATA)     ? {20'h0, data_reg} :
    (dpAddr_reg == ADDR_IRQ_STAT) ? {30'h0, irqStat_reg} :
    (dpAddr_reg == ADDR_IRQ_MASK) ? {30'h0, irqMask_reg} : 32'h00000000;

  // Interrupt events
  wire [1:0] irqEvent = {badCode | (frameEnd & ~ackOk), frameEnd};

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start) state_next = ST_XFER;
      ST_XFER: if (frameEnd) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Bus phase tracking; reads take one wait state so hrdata is a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dpWrite_reg <= 1'b0;
      dpAddr_reg  <= 32'h00000000;
      rdWait_reg  <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end
    else
    begin
      dpWrite_reg <= addrPhase & hwrite;
      if (addrPhase)
        dpAddr_reg <= haddr;
      rdWait_reg  <= addrPhase & ~hwrite;
      if (rdWait_reg)
        hrdata_reg <= readMux;
    end
  end

  assign hreadyout = ~rdWait_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Sequencer and shifters; frame is start, code, byte, acknowledge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg   <= ST_IDLE;
      phase_reg   <= 3'd0;
      bitIdx_reg  <= 4'd0;
      txShift_reg <= 13'h0000;
      rxShift_reg <= 8'h00;
      sclk_reg    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sclk_reg  <= sclkNext;
      if (start)
      begin
        phase_reg   <= 3'd0;
        bitIdx_reg  <= 4'd0;
        txShift_reg <= {1'b1, cmdByte[3:0], data_reg[7:0]};
      end
      else if (busy)
      begin
        phase_reg <= bitEnd ? 3'd0 : phase_reg + 3'd1;
        if (bitEnd)
        begin
          bitIdx_reg  <= bitIdx_reg + 4'd1;
          txShift_reg <= {txShift_reg[11:0], 1'b0};
          if (inByte)
            rxShift_reg <= {rxShift_reg[6:0], sdaSync};
        end
      end
    end
  end

  // Far die samples on the rising edge; we drive code, and byte on writes
  assign sclkOut = sclk_reg;
  assign sdaOut  = txShift_reg[12];
  assign sdaOe   = busy & (bitIdx_reg <= (isRead_reg ? OUT_LAST_RD : OUT_LAST_WR));

  // Command latch, completion status and data register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      code_reg   <= 4'h0;
      isRead_reg <= 1'b0;
      txByte_reg <= 8'h00;
      txOk_reg   <= 1'b0;
      rxOk_reg   <= 1'b0;
      data_reg   <= DATA_RESET;
    end
    else
    begin
      if (start)
      begin
        code_reg      <= cmdByte[3:0];
        isRead_reg    <= codeIsRead;
        txByte_reg    <= data_reg[7:0];
        data_reg[11:8] <= cmdByte[3:0];
      end
      else if (wrData)
        data_reg[7:0] <= hwdata[7:0];
      if (badCode)
      begin
        txOk_reg <= 1'b0;
        rxOk_reg <= 1'b0;
      end
      else if (frameEnd)
      begin
        txOk_reg <= ackOk;
        rxOk_reg <= ackOk & isRead_reg;
        if (ackOk & isRead_reg)
          data_reg[7:0] <= rxShift_reg;
      end
    end
  end

  // Config mirrors follow acknowledged writes only
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfgFirst_reg  <= CFG_RESET;
      cfgSecond_reg <= CFG_RESET;
    end
    else if (frameEnd & ackOk & ~isRead_reg)
    begin
      if (code_reg == CMD_WR_CFG1[3:0])
        cfgFirst_reg <= txByte_reg;
      else
        cfgSecond_reg <= txByte_reg;
    end
  end

  assign cfgFirst  = cfgFirst_reg;
  assign cfgSecond = cfgSecond_reg;

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqStat_reg <= 2'b00;
      irqMask_reg <= 2'b00;
    end
    else
    begin
      irqStat_reg <= (irqStat_reg & ~(wrStat ? hwdata[1:0] : 2'b00)) | irqEvent;
      if (wrMask)
        irqMask_reg <= hwdata[1:0];
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // Busy length counter for the latency check; saturates so it never wraps
  logic [7:0] busyCnt_reg;

  always_ff @(posedge mclk)
  begin
    if (rst | ~busy)
      busyCnt_reg <= 8'h00;
    else if (busyCnt_reg != 8'hFF)
      busyCnt_reg <= busyCnt_reg + 8'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_busy_set: assert property (start |=> busy)
    else $error("busy not set after command");
  a_busy_bound: assert property (start |-> ##[1:200] !busy)
    else $error("command took longer than latency limit");
  a_done_clears: assert property (frameEnd |=> !busy && txOk_reg == $past(sdaSync))
    else $error("status not valid when busy clears");
  a_send_status: assert property (badCode |=> !busy && !txOk_reg && !rxOk_reg)
    else $error("reserved code not reported as failed");
  a_read_data: assert property (frameEnd && ackOk && isRead_reg
      |=> rxOk_reg && data_reg[7:0] == $past(rxShift_reg))
    else $error("read byte not loaded");
  a_code_tag: assert property (start |=> data_reg[11:8] == $past(cmdByte[3:0]))
    else $error("data code field wrong");
  a_frame_head: assert property (start
      |=> txShift_reg[12:8] == {1'b1, $past(cmdByte[3:0])})
    else $error("frame head wrong");
  a_clock_high: assert property ($rose(sclk_reg) && busy |-> sclk_reg[*4] ##1 !sclk_reg)
    else $error("serial clock high phase wrong");
  a_cfg_write: assert property (frameEnd && ackOk && !isRead_reg
      && code_reg == 4'h8 |=> cfgFirst_reg == $past(txByte_reg))
    else $error("first config mirror not updated");
  a_busy_ignore: assert property (wrCmd && busy |=> $stable(code_reg))
    else $error("command taken while busy");

  // Frame shape, line ownership and bus view
  a_busy_length: assert property (busyCnt_reg < 8'(LATENCY_CYC))
    else $error("busy longer than latency limit");
  a_clock_idle: assert property (!busy |-> !sclk_reg)
    else $error("serial clock moved outside a frame");
  a_start_bit: assert property (start |=> sdaOe && sdaOut)
    else $error("start bit not driven high");
  a_data_sent: assert property (start |=> txShift_reg[7:0] == $past(data_reg[7:0]))
    else $error("write byte not loaded into frame");
  a_byte_order: assert property (busy && !isRead_reg
      && bitIdx_reg == OUT_LAST_RD + 4'h1 |-> sdaOut == txByte_reg[7])
    else $error("write byte not sent high bit first");
  a_reserved_zero: assert property (rdWait_reg && dpAddr_reg == ADDR_CMD
      |=> hrdata_reg[31:3] == 29'h0)
    else $error("reserved command bits not zero");
  a_fail_flag: assert property (frameEnd && !ackOk |=> irqStat_reg[IRQ_FAIL])
    else $error("refused frame not flagged");
  a_stat_sticky: assert property (irqStat_reg[IRQ_DONE] && !wrStat |=> irqStat_reg[IRQ_DONE])
    else $error("done flag lost without a clear");
  a_one_wait: assert property (!hreadyout |=> hreadyout)
    else $error("read wait longer than one cycle");

  c_read_done: cover property (frameEnd && isRead_reg && ackOk);
  c_write_done: cover property (frameEnd && !isRead_reg && ackOk);
  c_bad_code: cover property (badCode);
  c_irq_raise: cover property ($rose(irq));
  c_refused: cover property (frameEnd && !ackOk);
endmodule
`default_nettype wire

// [tb/hvii_far_die.sv]
/*
  Behavioural model of the register logic on the high voltage die.
  Assumes the frame format of the device and a pulled-up data line.
*/
`timescale 1ns/100ps
`default_nettype none
module hvii_far_die
  import hvii_pkg::*;
#(
  parameter logic [7:0] STA_VAL = 8'h5A, // Plain status value
  parameter logic [7:0] MON_VAL = 8'hC3  // Plain monitor value
)
(
  input  wire logic       mclk,   // System clock, edge finder only
  input  wire logic       rst,    // Synchronous reset
  input  wire logic       sclk,   // Serial clock from device
  input  wire logic       sda,    // Resolved data line
  input  wire logic       ackEn,  // Low forces a refused frame
  output logic            farOut, // Value driven on data line
  output logic            farOe   // High while driving data line
);
  logic       sclkPrev;
  logic [3:0] bitCnt;
  logic [3:0] code;
  logic [7:0] shiftIn;
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  wire        rise = sclk & ~sclkPrev;
  wire        fall = ~sclk & sclkPrev;
  // Read source picked by the low code bits
  wire  [7:0] rdVal = (code[1:0] == 2'h0) ? cfg1 : (code[1:0] == 2'h1) ? cfg2 :
                      (code[1:0] == 2'h2) ? STA_VAL : MON_VAL;
  // Sample on rise, change on fall, so the line settles a half bit early
  always_ff @(posedge mclk)
    if (rst)
    begin
      sclkPrev <= 1'b0;
      bitCnt   <= 4'h0;
      code     <= 4'h0;
      shiftIn  <= 8'h00;
      cfg1     <= CFG_RESET;
      cfg2     <= CFG_RESET;
      farOut   <= 1'b0;
      farOe    <= 1'b0;
    end
    else
    begin
      sclkPrev <= sclk;
      if (rise && bitCnt >= 4'h1 && bitCnt <= 4'h4)
        code <= {code[2:0], sda};
      if (rise && bitCnt >= 4'h5 && bitCnt <= 4'hC)
        shiftIn <= {shiftIn[6:0], sda};
      if (fall)
      begin
        bitCnt <= (bitCnt == 4'hD) ? 4'h0 : bitCnt + 4'h1;
        farOe  <= 1'b0;
        farOut <= ~farOut; // Stale value never lingers
        if (bitCnt >= 4'h4 && bitCnt <= 4'hB && !code[3])
        begin
          farOe  <= 1'b1;
          farOut <= rdVal[4'hB - bitCnt];
        end
        if (bitCnt == 4'hC)
        begin
          farOe  <= 1'b1;
          farOut <= ackEn; // Refusal driven low, pull-up would fake success
          if (ackEn && code[3] && code[0])
            cfg2 <= shiftIn;
          if (ackEn && code[3] && !code[0])
            cfg1 <= shiftIn;
        end
      end
    end
endmodule
`default_nettype wire

// [tb/hvii_top_tb.sv]
/*
  Self-checking bench for the indirect register interface: AHB-Lite
  master tasks and a far die model. Assumes single word transfers only.
*/
`timescale 1ns/100ps
`default_nettype none
module hvii_top_tb
  import hvii_pkg::*;
;
  localparam logic [7:0] STA_V = 8'h5A;
  localparam logic [7:0] MON_V = 8'hC3;
  logic mclk, rst, hsel, hwrite, ackEn;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hreadyout, hresp, sclkOut, sdaOut, sdaOe, irq, farOut, farOe;
  wire  [31:0] hrdata;
  wire  [7:0]  cfgFirst, cfgSecond;
  int          miscompares, nTests, el;
  int          cyc = 0;
  logic [7:0]  wCode [2] = '{CMD_WR_CFG1, CMD_WR_CFG2};
  logic [7:0]  val [4] = '{8'hA5, 8'h3C, STA_V, MON_V};
  // Line pulled up when nobody drives it
  wire sdaLine = sdaOe ? sdaOut : (farOe ? farOut : 1'b1);

  hvii_top uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclkOut(sclkOut),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq),
    .cfgFirst(cfgFirst), .cfgSecond(cfgSecond));
  hvii_far_die #(.STA_VAL(STA_V), .MON_VAL(MON_V)) far (.mclk(mclk), .rst(rst),
    .sclk(sclkOut), .sda(sdaLine), .ackEn(ackEn), .farOut(farOut), .farOe(farOe));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // One single transfer; called right after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'b010;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    nTests++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // Command write, first status read, then poll until idle (bounded)
  task automatic cmdRun(input logic [7:0] c, output logic [31:0] first);
    int t0, i;
    bus(1'b1, ADDR_CMD, {24'h0, c}, rd);
    t0 = cyc;
    bus(1'b0, ADDR_CMD, 32'h0, first);
    rd = first;
    for (i = 0; i < 200 && rd[BUSY_BIT] !== 1'b0; i++) bus(1'b0, ADDR_CMD, 32'h0, rd);
    el = cyc - t0;
    if (i >= 200)
    begin
      $display("mismatch at %0t busy poll limit got %h expected %h", $time, rd, 32'h0);
      miscompares++;
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #(50 * 20000);
    miscompares++;
    test_done();
  end

  initial
  begin
    logic [31:0] f;
    miscompares = 0; nTests = 0; ackEn = 1'b1; rst = 1'b1;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset state and an unmapped address
    bus(1'b0, ADDR_CMD, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, ADDR_DATA, 32'h0, rd); chk(rd, {20'h0, DATA_RESET});
    chk({cfgFirst, cfgSecond, 7'h0, irq}, {CFG_RESET, CFG_RESET, 8'h00});
    bus(1'b0, 32'hFFFF0800, 32'h0, rd); chk(rd, 32'h0);
    $display("test reset done");
    // Both writes: busy while running, latency, status, code in data
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, ADDR_DATA, {24'h0, val[k]}, rd);
      cmdRun(wCode[k], f);
      chk(f[BUSY_BIT], 1'b1);
      chk(el <= LATENCY_CYC, 1'b1);
      chk(rd, 32'h4);
      bus(1'b0, ADDR_DATA, 32'h0, rd); chk(rd, {20'h0, wCode[k][3:0], val[k]});
    end
    chk({cfgFirst, cfgSecond}, {val[0], val[1]});
    $display("test write done");
    // All four reads; data byte cleared first, then replaced by the returned byte
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, ADDR_DATA, 32'h0, rd);
      cmdRun(8'(k), f);
      chk(el <= LATENCY_CYC, 1'b1);
      chk(rd, 32'h6);
      bus(1'b0, ADDR_DATA, 32'h0, rd); chk(rd, {20'h0, 4'(k), val[k]});
    end
    $display("test read done");
    // Interrupt: sticky done bit, mask, write one to clear
    bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd); chk(rd, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h3, rd); @(posedge mclk); chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1, rd); @(posedge mclk); chk(irq, 1'b0);
    $display("test irq done");
    // Reserved code: no frame, status cleared, failure flagged
    cmdRun(8'h05, f);
    chk(f, 32'h0);
    bus(1'b0, ADDR_DATA, 32'h0, rd); chk(rd, {20'h0, 4'h3, MON_V});
    bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd); chk(rd, 32'h2);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h3, rd);
    $display("test reserved done");
    // Refused frame: send status fails, mirror keeps its value
    ackEn <= 1'b0;
    bus(1'b1, ADDR_DATA, 32'h77, rd);
    cmdRun(CMD_WR_CFG1, f);
    chk(rd, 32'h0);
    chk(cfgFirst, val[0]);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd); chk(rd, 32'h3);
    $display("test refused done");
    test_done();
  end
endmodule
`default_nettype wire
